// *** hdl/pfd_defs.svh ***
// constants for the positioning frame link and controller registers
`ifndef PFD_DEFS_SVH
`define PFD_DEFS_SVH
// Function
// (RULE_01) long two-motor frame: id 0x3c, 0x80, 0x8b
// (RULE_02) node takes slot matching its 7-bit address
// (RULE_03) short 11-bit half-step position scaled internally
// (RULE_04) stepping mode kept; target on half steps
// (RULE_05) 4-bit address compared with stored bits
// (RULE_06) hardwired address inputs preferably tied high
// (RULE_07) one-motor short frame: two bytes layout
// (RULE_08) broadcast flag zero moves every node
// (RULE_09) two-motor short frame: four bytes, id 10
// (RULE_10) four-motor short frame: eight bytes, id 11
// (RULE_11) pick slot by low address, signed value
// (RULE_12) param move sets position and velocities
// (RULE_13) param frame: position, velocities, threshold, accel
// (RULE_14) master gives each node own param id
// (RULE_15) id parity generated and checked
// (RULE_16) bad parity or checksum leaves state unchanged

// frame contents
`define PFD_ID_REQ     6'h3c
`define PFD_APP_CMD    8'h80
`define PFD_CMD_POS    8'h8b
`define PFD_LEN_LONG   4'h8
`define PFD_LEN_ONE    4'h2
`define PFD_LEN_TWO    4'h4
`define PFD_LEN_FOUR   4'h8
`define PFD_LEN_PARAM  4'h4
`define PFD_LEN_MAX    4'h8
`define PFD_GRP_TWO    2'h2
`define PFD_GRP_FOUR   2'h3
`define PFD_FLAG_BIT   4
// controller register offsets
`define PFD_REG_CTRL   4'h0
`define PFD_REG_DLO    4'h4
`define PFD_REG_DHI    4'h8
`define PFD_REG_STAT   4'hc
// controller field positions
`define PFD_CTRL_LEN   8
`define PFD_STAT_CNT   8
// reset values
`define PFD_RST_BYTE   8'h00
`define PFD_RST_WORD   32'h0000_0000
`endif

// *** hdl/pfd_pkg.sv ***
// types and shared coding functions of the positioning frame link
package pfd_pkg;
  // receiver states
  typedef enum logic [0:0] {RX_IDLE, RX_DATA} pfd_rx_state_type;
  // sender states
  typedef enum logic [1:0] {TX_IDLE, TX_ID, TX_DATA, TX_CSUM} pfd_tx_state_type;

  // identifier with its two parity bits on top
  function automatic logic [7:0] pfd_protect(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction : pfd_protect

  // sum with end-around carry
  function automatic logic [7:0] pfd_csum_add(input logic [7:0] s, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction : pfd_csum_add
endpackage : pfd_pkg

// *** hdl/pfd_link_if.sv ***
// byte link between frame controller and motor node
`timescale 1ns/1ps
interface pfd_link_if;
  logic [7:0] linkByte;   // byte on the link
  logic       linkValid;  // byte strobe
  logic       linkFirst;  // identifier byte
  logic       linkLast;   // checksum byte
  // frame sender
  modport ctrl (output linkByte, output linkValid, output linkFirst, output linkLast);
  // motor node receiver
  modport node (input linkByte, input linkValid, input linkFirst, input linkLast);
endinterface : pfd_link_if

// *** hdl/pfd_node.sv ***
// motor node decoder for positioning frames
`timescale 1ns/1ps
`include "pfd_defs.svh"
module pfd_node (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  pfd_link_if.node        link,
  input  wire logic [6:0] nodeAddr,
  input  wire logic [3:0] storedAddr,
  input  wire logic [1:0] stepMode,
  input  wire logic [5:0] idShortOne,
  input  wire logic [5:0] idShortTwo,
  input  wire logic [5:0] idShortFour,
  input  wire logic [5:0] idPosParam,
  output logic      [15:0] targetPos,
  output logic             targetLoad,
  output logic      [3:0]  maxVel,
  output logic      [3:0]  minVel,
  output logic      [3:0]  accel,
  output logic      [3:0]  stallThr,
  output logic             paramLoad,
  output logic             frameErr
);

  // receiver state
  pfd_pkg::pfd_rx_state_type state_q;
  // frame identifier, six bits
  logic [5:0]  id_q;
  // identifier parity correct
  logic        idOk_q;
  // data bytes held
  logic [3:0]  cnt_q;
  // running checksum
  logic [7:0]  sum_q;
  // too many data bytes
  logic        over_q;
  // data bytes one to eight
  logic [7:0]  buf_q [1:8];
  // registered results
  logic [15:0] pos_q;
  logic        posLd_q;
  logic [3:0]  vmax_q;
  logic [3:0]  vmin_q;
  logic [3:0]  acc_q;
  logic [3:0]  thr_q;
  logic        parLd_q;
  logic        err_q;
  // hardwired address pins, three-stage filter
  logic [6:0]  addrS1_q;
  logic [6:0]  addrS2_q;
  logic [6:0]  addrS3_q;
  logic [6:0]  addr_q;
  // decode results
  logic        frameEnd;
  logic        frameGood;
  logic        loadPos;
  logic        loadPar;
  logic [15:0] newPos;

  // short position to internal microstep units
  function automatic logic [15:0] scaleShort(input logic [10:0] p, input logic [1:0] m);
    logic [15:0] e;
    e = {{5{p[10]}}, p};
    return e << m;
  endfunction : scaleShort

  // short slot match: flag set and address equal
  function automatic logic slotHit(input logic [7:0] b, input logic [3:0] a);
    return b[`PFD_FLAG_BIT] && (b[3:0] == a);
  endfunction : slotHit

  // checksum byte closes a started frame
  assign frameEnd = link.linkValid && link.linkLast && !link.linkFirst
                    && (state_q == pfd_pkg::RX_DATA);
  // parity, length and inverted sum all correct
  assign frameGood = idOk_q && !over_q && (~sum_q == link.linkByte); // RULE_15

  // address pins: a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrS1_q <= 7'h00;
      addrS2_q <= 7'h00;
      addrS3_q <= 7'h00;
      addr_q   <= 7'h00;
    end else begin
      addrS1_q <= nodeAddr;
      addrS2_q <= addrS1_q;
      addrS3_q <= addrS2_q;
      if (addrS2_q == addrS3_q) begin
        // settled pin value
        addr_q <= addrS3_q;
      end
    end
  end

  // frame collection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pfd_pkg::RX_IDLE;
      id_q    <= 6'h00;
      idOk_q  <= 1'b0;
      cnt_q   <= 4'h0;
      sum_q   <= `PFD_RST_BYTE;
      over_q  <= 1'b0;
      for (int i = 1; i <= 8; i++) begin
        buf_q[i] <= `PFD_RST_BYTE;
      end
    end else if (link.linkValid) begin
      if (link.linkFirst) begin
        // identifier byte restarts any frame
        id_q    <= link.linkByte[5:0];
        idOk_q  <= (pfd_pkg::pfd_protect(link.linkByte[5:0]) == link.linkByte); // RULE_15
        cnt_q   <= 4'h0;
        sum_q   <= `PFD_RST_BYTE;
        over_q  <= 1'b0;
        state_q <= pfd_pkg::RX_DATA;
      end else begin
        case (state_q)
          pfd_pkg::RX_DATA: begin
            if (link.linkLast) begin
              // checksum byte ends frame
              state_q <= pfd_pkg::RX_IDLE;
            end else if (cnt_q == `PFD_LEN_MAX) begin
              // surplus byte spoils frame
              over_q <= 1'b1;
            end else begin
              buf_q[cnt_q + 4'h1] <= link.linkByte;
              cnt_q <= cnt_q + 4'h1;
              sum_q <= pfd_pkg::pfd_csum_add(sum_q, link.linkByte);
            end
          end
          default: begin
            // stray byte outside a frame ignored
            state_q <= pfd_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // command decode on the held bytes
  always_comb begin
    loadPos = 1'b0;
    loadPar = 1'b0;
    newPos  = 16'h0000;
    if (id_q == `PFD_ID_REQ && cnt_q == `PFD_LEN_LONG
        && buf_q[1] == `PFD_APP_CMD && buf_q[2] == `PFD_CMD_POS
        && buf_q[3][7] && buf_q[6][7]) begin // RULE_01
      // long frame, two 7-bit slots
      if (buf_q[3][6:0] == addr_q) begin // RULE_02
        loadPos = 1'b1;
        newPos  = {buf_q[4], buf_q[5]};
      end else if (buf_q[6][6:0] == addr_q) begin // RULE_02
        loadPos = 1'b1;
        newPos  = {buf_q[7], buf_q[8]};
      end
    end else if (id_q == idShortOne && cnt_q == `PFD_LEN_ONE) begin // RULE_07
      // one motor, broadcast or own address
      if (!buf_q[1][`PFD_FLAG_BIT] || buf_q[1][3:0] == storedAddr) begin // RULE_08 RULE_05
        loadPos = 1'b1;
        newPos  = scaleShort({buf_q[1][7:5], buf_q[2]}, stepMode); // RULE_03 RULE_04
      end
    end else if ((id_q == idShortTwo && id_q[5:4] == `PFD_GRP_TWO
                  && cnt_q == `PFD_LEN_TWO) // RULE_09
                 || (id_q == idShortFour && id_q[5:4] == `PFD_GRP_FOUR
                  && cnt_q == `PFD_LEN_FOUR)) begin // RULE_10
      // first slot with matching address wins
      for (int s = 0; s < 4; s++) begin
        if (!loadPos && (4'(2 * s + 2) <= cnt_q)
            && slotHit(buf_q[2 * s + 1], storedAddr)) begin // RULE_11 RULE_05
          loadPos = 1'b1;
          newPos  = scaleShort({buf_q[2 * s + 1][7:5], buf_q[2 * s + 2]}, stepMode); // RULE_03
        end
      end
    end else if (id_q == idPosParam && cnt_q == `PFD_LEN_PARAM) begin // RULE_13
      // move plus motion parameters
      loadPos = 1'b1;
      loadPar = 1'b1; // RULE_12
      newPos  = {buf_q[1], buf_q[2]};
    end
  end

  // target position register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q   <= 16'h0000;
      posLd_q <= 1'b0;
    end else begin
      posLd_q <= frameEnd && frameGood && loadPos; // RULE_16
      if (frameEnd && frameGood && loadPos) begin // RULE_16
        pos_q <= newPos;
      end
    end
  end

  // motion parameter registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vmax_q  <= 4'h0;
      vmin_q  <= 4'h0;
      acc_q   <= 4'h0;
      thr_q   <= 4'h0;
      parLd_q <= 1'b0;
    end else begin
      parLd_q <= frameEnd && frameGood && loadPar;
      if (frameEnd && frameGood && loadPar) begin // RULE_12 RULE_16
        vmax_q <= buf_q[3][7:4]; // RULE_13
        vmin_q <= buf_q[3][3:0];
        thr_q  <= buf_q[4][7:4];
        acc_q  <= buf_q[4][3:0];
      end
    end
  end

  // discarded frame report
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= frameEnd && !frameGood; // RULE_16
    end
  end

  // outputs straight from registers
  assign targetPos  = pos_q;
  assign targetLoad = posLd_q;
  assign maxVel     = vmax_q;
  assign minVel     = vmin_q;
  assign accel      = acc_q;
  assign stallThr   = thr_q;
  assign paramLoad  = parLd_q;
  assign frameErr   = err_q;

endmodule : pfd_node

// *** hdl/pfd_ctrl.sv ***
// frame controller: wishbone registers and frame sender
`timescale 1ns/1ps
`include "pfd_defs.svh"
module pfd_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  pfd_link_if.ctrl         link
);

  // sender state
  pfd_pkg::pfd_tx_state_type state_q;
  // identifier and length to send
  logic [5:0]  id_q;
  logic [3:0]  len_q;
  // frame data bytes
  logic [7:0]  data_q [0:7];
  // byte index, checksum, frame count
  logic [2:0]  idx_q;
  logic [7:0]  sum_q;
  logic [7:0]  sent_q;
  // bus answer
  logic        ack_q;
  logic [31:0] rdat_q;
  // link outputs
  logic [7:0]  byte_q;
  logic        valid_q;
  logic        first_q;
  logic        last_q;
  // bus write taken, frame start
  logic        wbWr;
  logic        start;

  assign wbWr  = cyc_i && stb_i && we_i && ack_q;
  assign start = wbWr && (adr_i == `PFD_REG_CTRL) && (state_q == pfd_pkg::TX_IDLE)
                 && (dat_i[`PFD_CTRL_LEN +: 4] <= `PFD_LEN_MAX);

  // wishbone answer one cycle after request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= `PFD_RST_WORD;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
      case (adr_i)
        `PFD_REG_CTRL: rdat_q <= {20'h00000, len_q, 2'h0, id_q};
        `PFD_REG_DLO:  rdat_q <= {data_q[3], data_q[2], data_q[1], data_q[0]};
        `PFD_REG_DHI:  rdat_q <= {data_q[7], data_q[6], data_q[5], data_q[4]};
        `PFD_REG_STAT: rdat_q <= {16'h0000, sent_q, 7'h00, state_q != pfd_pkg::TX_IDLE};
        default:       rdat_q <= `PFD_RST_WORD;
      endcase
    end
  end

  // frame setup registers, held while busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_q  <= 6'h00;
      len_q <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= `PFD_RST_BYTE;
      end
    end else if (wbWr && state_q == pfd_pkg::TX_IDLE) begin
      if (start) begin
        // software gives each node its own param id
        id_q  <= dat_i[5:0]; // RULE_14
        len_q <= dat_i[`PFD_CTRL_LEN +: 4];
      end
      for (int l = 0; l < 4; l++) begin
        if (sel_i[l] && adr_i == `PFD_REG_DLO) begin
          data_q[l] <= dat_i[8 * l +: 8];
        end
        if (sel_i[l] && adr_i == `PFD_REG_DHI) begin
          data_q[l + 4] <= dat_i[8 * l +: 8];
        end
      end
    end
  end

  // byte sender
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pfd_pkg::TX_IDLE;
      idx_q   <= 3'h0;
      sum_q   <= `PFD_RST_BYTE;
      sent_q  <= 8'h00;
      byte_q  <= `PFD_RST_BYTE;
      valid_q <= 1'b0;
      first_q <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      case (state_q)
        pfd_pkg::TX_IDLE: begin
          valid_q <= 1'b0;
          last_q  <= 1'b0;
          if (start) begin
            state_q <= pfd_pkg::TX_ID;
          end
        end
        pfd_pkg::TX_ID: begin
          // identifier with parity
          byte_q  <= pfd_pkg::pfd_protect(id_q); // RULE_15
          valid_q <= 1'b1;
          first_q <= 1'b1;
          idx_q   <= 3'h0;
          sum_q   <= `PFD_RST_BYTE;
          state_q <= (len_q == 4'h0) ? pfd_pkg::TX_CSUM : pfd_pkg::TX_DATA;
        end
        pfd_pkg::TX_DATA: begin
          byte_q  <= data_q[idx_q];
          first_q <= 1'b0;
          sum_q   <= pfd_pkg::pfd_csum_add(sum_q, data_q[idx_q]);
          idx_q   <= idx_q + 3'h1;
          if ({1'b0, idx_q} == len_q - 4'h1) begin
            state_q <= pfd_pkg::TX_CSUM;
          end
        end
        pfd_pkg::TX_CSUM: begin
          // inverted carry sum closes frame
          byte_q  <= ~sum_q;
          first_q <= 1'b0;
          last_q  <= 1'b1;
          sent_q  <= sent_q + 8'h01;
          state_q <= pfd_pkg::TX_IDLE;
        end
        default: begin
          state_q <= pfd_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // outputs from registers
  assign dat_o          = rdat_q;
  assign ack_o          = ack_q;
  assign link.linkByte  = byte_q;
  assign link.linkValid = valid_q;
  assign link.linkFirst = first_q;
  assign link.linkLast  = last_q;

endmodule : pfd_ctrl

// *** bench/pfd_link_sva.sv ***
// assertions on the frame link and on the motor node outputs
`timescale 1ns/1ps
module pfd_link_sva (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  linkByte,
  input wire logic        linkValid,
  input wire logic        linkFirst,
  input wire logic        linkLast,
  input wire logic [15:0] targetPos,
  input wire logic        targetLoad,
  input wire logic [3:0]  maxVel,
  input wire logic [3:0]  minVel,
  input wire logic [3:0]  accel,
  input wire logic [3:0]  stallThr,
  input wire logic        paramLoad
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // expected parity pair for a six-bit id
  function automatic logic [1:0] par(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4]};
  endfunction : par
  chk_id_parity: assert property (
    linkValid && linkFirst |-> linkByte[7:6] == par(linkByte[5:0]))
    else $error("id parity bits wrong");
  chk_frame_end: assert property (
    linkValid && linkFirst |-> ##[1:9] (linkValid && linkLast))
    else $error("frame not closed in time");
  chk_link_idle: assert property (
    linkValid && linkLast |=> !linkValid)
    else $error("link busy after checksum");
  chk_load_cause: assert property (
    targetLoad |-> $past(linkValid && linkLast))
    else $error("load without checksum byte");
  chk_load_pulse: assert property (
    targetLoad |=> !targetLoad)
    else $error("load pulse too long");
  chk_param_pair: assert property (
    paramLoad |-> targetLoad)
    else $error("params loaded without move");
  chk_param_hold: assert property (
    !paramLoad |-> $stable({maxVel, minVel, accel, stallThr}))
    else $error("params changed without load");
  chk_target_hold: assert property (
    !targetLoad |-> $stable(targetPos))
    else $error("target changed without load");
endmodule : pfd_link_sva

// *** bench/positioning_frame_decoder_bench.sv ***
// self-checking bench: controller sends frames to a motor node
`timescale 1ns/1ps
module positioning_frame_decoder_bench;
  localparam logic [5:0] ID_ONE = 6'h05;  // short one-motor id
  localparam logic [5:0] ID_TWO = 6'h21;  // short two-motor id
  localparam logic [5:0] ID_FOUR = 6'h32; // short four-motor id
  localparam logic [5:0] ID_PAR = 6'h2a;  // move-with-params id
  logic        ref_clk, rst_n, cyc_i, stb_i, we_i;  // clock, reset, bus strobes
  logic [3:0]  adr_i, sel_i, storedAddr, maxVel, minVel, accel, stallThr, sa;
  logic [31:0] dat_i, dat_o, r;  // bus data
  logic        ack_o, targetLoad, paramLoad, frameErr, fLoad, fErr;
  logic [6:0]  nodeAddr, na;     // node address
  logic [1:0]  stepMode;         // step resolution
  logic [15:0] targetPos, fPos, q, v, e;
  logic [10:0] p;                // short position
  logic [63:0] d;                // frame data bytes
  logic [7:0]  idSeen, b1, s;    // last id byte on the wire
  int          errors, checked, cycles, nSent;
  pfd_link_if lnk ();
  pfd_link_if lnkB ();
  pfd_ctrl pfd_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .link(lnk));
  pfd_node pfd_node_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(lnk), .nodeAddr(nodeAddr),
    .storedAddr(storedAddr), .stepMode(stepMode), .idShortOne(ID_ONE),
    .idShortTwo(ID_TWO), .idShortFour(ID_FOUR), .idPosParam(ID_PAR),
    .targetPos(targetPos), .targetLoad(targetLoad), .maxVel(maxVel), .minVel(minVel),
    .accel(accel), .stallThr(stallThr), .paramLoad(paramLoad), .frameErr(frameErr));
  // second node fed by the bench to inject broken frames
  pfd_node pfd_node_fault_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(lnkB),
    .nodeAddr(nodeAddr), .storedAddr(storedAddr), .stepMode(stepMode),
    .idShortOne(ID_ONE), .idShortTwo(ID_TWO), .idShortFour(ID_FOUR), .idPosParam(ID_PAR),
    .targetPos(fPos), .targetLoad(fLoad), .maxVel(), .minVel(), .accel(), .stallThr(),
    .paramLoad(), .frameErr(fErr));
  pfd_link_sva pfd_link_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .linkByte(lnk.linkByte),
    .linkValid(lnk.linkValid), .linkFirst(lnk.linkFirst), .linkLast(lnk.linkLast),
    .targetPos(targetPos), .targetLoad(targetLoad), .maxVel(maxVel), .minVel(minVel),
    .accel(accel), .stallThr(stallThr), .paramLoad(paramLoad));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard and id byte monitor
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (lnk.linkValid && lnk.linkFirst) idSeen <= lnk.linkByte;
    if (cycles == 30000) begin
      errors++;
      test_done();
    end
  end
  // id with parity on top
  function automatic logic [7:0] par(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : par
  // short position scaled to internal units
  function automatic logic [15:0] sc(input logic [10:0] x, input logic [1:0] m);
    logic [15:0] t;
    t = {{5{x[10]}}, x};
    return t << m;
  endfunction : sc
  // short slot, first byte in low half
  function automatic logic [15:0] sl(input logic [10:0] x, input logic [3:0] a, input logic f);
    return {x[7:0], x[10:8], f, a};
  endfunction : sl
  // inverted end-around carry sum of two bytes
  function automatic logic [7:0] cs(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] t;
    t = {1'b0, x} + {1'b0, y};
    return ~(t[7:0] + {7'h00, t[8]});
  endfunction : cs
  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) fail(m);
  endtask : chk
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] x,
                    output logic [31:0] rd);
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hf;
    adr_i <= a;
    dat_i <= x;
    // wait for the answer; a lost ack ends in the hang guard
    do begin
      @(posedge ref_clk);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // send a frame through the controller and judge the node
  task automatic go(input logic [5:0] id, input logic [3:0] len, input logic [63:0] x,
                    input logic ld, input logic [15:0] ep);
    logic [31:0] rd;
    int n;
    logic drop;
    wb(1'b1, 4'h4, x[31:0], rd);
    wb(1'b1, 4'h8, x[63:32], rd);
    wb(1'b1, 4'h0, {20'h0, len, 2'h0, id}, rd);
    nSent++;
    n = 0;
    drop = 1'b0;
    while (targetLoad !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      drop = drop | (frameErr === 1'b1);
      n++;
    end
    chk(idSeen === par(id), "id byte");
    chk((n < 20) === ld, "load");
    chk(!drop, "good frame dropped");
    if (ld) chk(targetPos === ep, "target");
    if (ld) chk(paramLoad === (id == ID_PAR), "param load");
  endtask : go
  // drive a raw two-byte frame on the fault link
  task automatic raw(input logic [7:0] b0, input logic [7:0] x1, input logic [7:0] x2,
                     input logic [7:0] cs0, input logic err);
    int n;
    @(posedge ref_clk);
    lnkB.linkValid <= 1'b1;
    lnkB.linkFirst <= 1'b1;
    lnkB.linkByte <= b0;
    @(posedge ref_clk);
    lnkB.linkFirst <= 1'b0;
    lnkB.linkByte <= x1;
    @(posedge ref_clk);
    lnkB.linkByte <= x2;
    @(posedge ref_clk);
    lnkB.linkLast <= 1'b1;
    lnkB.linkByte <= cs0;
    @(posedge ref_clk);
    lnkB.linkValid <= 1'b0;
    lnkB.linkLast <= 1'b0;
    lnkB.linkByte <= ~cs0;
    n = 0;
    while (fLoad !== 1'b1 && fErr !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    chk(fErr === err, "error flag");
    chk(fLoad === !err, "fault node load");
  endtask : raw
  task automatic test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    {errors, checked, cycles, nSent} = '0;
    {rst_n, cyc_i, stb_i, we_i, adr_i, dat_i, stepMode} = '0;
    sel_i = 4'hf;
    nodeAddr = 7'h15;
    storedAddr = 4'h3;
    {lnkB.linkValid, lnkB.linkFirst, lnkB.linkLast, lnkB.linkByte} = '0;
    void'($urandom(32'hb398));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sa = 4'($urandom);
      na = {4'($urandom), 3'h7};
      p = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : 11'($urandom);
      q = 16'($urandom);
      v = 16'($urandom);
      @(posedge ref_clk);
      stepMode <= 2'(i);
      storedAddr <= sa;
      nodeAddr <= na;
      go(ID_ONE, 4'h2, {48'h0, sl(p, sa, 1'b1)}, 1'b1, sc(p, 2'(i)));
      go(ID_ONE, 4'h2, {48'h0, sl(~p, ~sa, 1'b0)}, 1'b1, sc(~p, 2'(i)));
      go(ID_ONE, 4'h2, {48'h0, sl(p, ~sa, 1'b1)}, 1'b0, 16'h0);
      go(ID_TWO, 4'h4, {32'h0, sl(p, sa, 1'b1), sl(~p, ~sa, 1'b1)}, 1'b1, sc(p, 2'(i)));
      d = {4{sl(~p, ~sa, 1'b1)}};
      d[16*i +: 16] = sl(p, sa, 1'b1);
      go(ID_FOUR, 4'h8, d, 1'b1, sc(p, 2'(i)));
      go(ID_PAR, 4'h4, {32'h0, v, q[7:0], q[15:8]}, 1'b1, q);
      chk({maxVel, minVel, stallThr, accel} === {v[7:0], v[15:8]}, "params");
      // odd passes match the first slot, even passes the second
      d = {q[7:0], q[15:8], 1'b1, na ^ {6'h00, i[0]}, v[7:0], v[15:8],
           1'b1, na ^ {6'h00, !i[0]}, 8'h8b, 8'h80};
      go(6'h3c, 4'h8, d, 1'b1, i[0] ? v : q);
    end
    b1 = {p[10:8], 5'h00};
    raw(par(ID_ONE), b1, p[7:0], cs(b1, p[7:0]), 1'b0);
    e = sc(p, 2'h3);
    chk(fPos === e, "fault node target");
    s = cs(b1 ^ 8'h20, p[7:0]);
    raw(par(ID_ONE) ^ 8'h40, b1 ^ 8'h20, p[7:0], s, 1'b1);
    raw(par(ID_ONE), b1 ^ 8'h20, p[7:0], s ^ 8'h01, 1'b1);
    chk(fPos === e, "target kept");
    wb(1'b0, 4'hc, 32'h0, r);
    chk(r[15:8] === nSent[7:0] && r[0] === 1'b0, "status");
    wb(1'b0, 4'h2, 32'h0, r);
    chk(r === 32'h0, "unmapped read");
    test_done();
  end
endmodule : positioning_frame_decoder_bench
